// File: rtl/legacy_attr_pkg.sv
/*
 * Constants, register map and carrier types of the legacy segment
 * attribute decoder. Assumes a 40 MHz aclk and a 20-bit legacy address.
 */
// Notes on behaviour
// [R1] Read-permit set: host reads claimed to DRAM
// [R2] Write-permit set: host writes claimed to DRAM
// [R3] Permits at bits 5,1 and 4,0; rest reserved
// [R4] Both clear: all to hub, no target reply
// [R5] Read only: reads DRAM, writes to hub
// [R6] Write only: writes DRAM, reads to hub
// [R7] Both set: reads and writes go DRAM
// [R8] Permits apply to host and hub initiators
// [R9] Thirteen segments over seven consecutive registers
// [R10] C0000h-DFFFFh: eight 16 kB segments, 5Ah-5Dh
// [R11] E0000h-EFFFFh: four segments in 5Eh, 5Fh
// [R12] F0000h-FFFFFh: one segment, 59h upper field
// [R13] Below 80000h always routed to DRAM
// [R14] 80000h-9FFFFh DRAM unless hole configured
// [R15] Video region ignores permits, goes downstream; the code sends host SMM accesses to DRAM when management is set
// [R16] Hub refused video when management or strapped
// [R17] Shadowing: write only, copy, then read only
// [R18] Reserved bits read zero; reset all zero
package legacy_attr_pkg;

	// ***********************************
	// Register bus
	// ***********************************
	localparam int ADDR_W = 12;
	localparam int NUM_ATTR = 7;
	localparam logic [9:0] IDX_BIOS_AREA = 10'h059;
	localparam logic [9:0] IDX_EXPANSION_A = 10'h05A;
	localparam logic [9:0] IDX_EXPANSION_B = 10'h05B;
	localparam logic [9:0] IDX_EXPANSION_C = 10'h05C;
	localparam logic [9:0] IDX_EXPANSION_D = 10'h05D;
	localparam logic [9:0] IDX_BIOS_EXT_A = 10'h05E;
	localparam logic [9:0] IDX_BIOS_EXT_B = 10'h05F;
	localparam logic [9:0] IDX_CONTROL = 10'h080;
	localparam logic [9:0] IDX_STATUS = 10'h081;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	// ***********************************
	// Attribute fields
	// ***********************************
	localparam int RP_LO = 0;
	localparam int WP_LO = 1;
	localparam int RP_HI = 4;
	localparam int WP_HI = 5;
	localparam logic [7:0] ATTR_MASK = 8'h33;
	localparam logic [7:0] BIOS_MASK = 8'h30;
	localparam logic [7:0] ATTR_RESET = 8'h00;
	localparam int CTRL_HOLE = 0;
	localparam int CTRL_MGMT = 1;
	localparam logic [1:0] CTRL_RESET = 2'h0;

	// ***********************************
	// Legacy address map
	// ***********************************
	localparam int MEM_AW = 20;
	localparam logic [19:0] DOS_TOP = 20'h80000;
	localparam logic [19:0] HOLE_TOP = 20'hA0000;
	localparam logic [19:0] VIDEO_TOP = 20'hC0000;
	localparam logic [19:0] BIOS_BASE = 20'hF0000;
	localparam int SEG_SHIFT = 14;
	localparam logic [2:0] FIRST_EXP_REG = 3'h1;
	localparam logic [2:0] BIOS_REG = 3'h0;

	// ***********************************
	// Carriers
	// ***********************************
	typedef struct packed {
		logic valid;
		logic write;
		logic smm;
		logic [MEM_AW-1:0] addr;
	} mem_req_t;

	typedef struct packed {
		logic valid;
		logic to_dram;
		logic refused;
	} route_t;

endpackage : legacy_attr_pkg

// File: rtl/legacy_segment_attribute_decoder.sv
/*
 * Legacy segment attribute decoder: AXI4-Lite register slave, host and
 * hub-side routing decision one cycle after each request.
 * Assumes requests come from logic on aclk; the strap is an async pin.
 */
`timescale 1ns/1ps
module legacy_segment_attribute_decoder
	import legacy_attr_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Write address
	input wire logic awvalid,
	output logic awready,
	input wire logic [legacy_attr_pkg::ADDR_W-1:0] awaddr,
	input wire logic [2:0] awprot,
	// Write data
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	// Write response
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	// Read address
	input wire logic arvalid,
	output logic arready,
	input wire logic [legacy_attr_pkg::ADDR_W-1:0] araddr,
	input wire logic [2:0] arprot,
	// Read data
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	// Access requests
	input wire legacy_attr_pkg::mem_req_t host_req,
	input wire legacy_attr_pkg::mem_req_t hub_req,
	// Routing decisions
	output legacy_attr_pkg::route_t host_route,
	output legacy_attr_pkg::route_t hub_route,
	// Strap pin
	input wire logic non_native_strap
);
	import legacy_attr_pkg::*;

	// ***********************************
	// State
	// ***********************************
	logic [NUM_ATTR-1:0][7:0] attr_r;
	logic [1:0] ctrl_r;
	logic aw_full_r, w_full_r;
	logic [ADDR_W-1:0] aw_addr_r;
	logic [31:0] w_data_r;
	logic [3:0] w_strb_r;
	logic strap_s1_r, strap_s2_r, strap_s3_r, strap_r;
	logic do_write;
	logic [9:0] wr_idx;

	// ***********************************
	// Decode functions
	// ***********************************
	function automatic logic reg_hit(input logic [ADDR_W-1:0] a,
			output logic [2:0] slot);
		logic [9:0] idx;
		idx = a[ADDR_W-1:2];
		slot = 3'(idx - IDX_BIOS_AREA);
		return (a[1:0] == 2'h0) && (idx >= IDX_BIOS_AREA) &&
			(idx <= IDX_BIOS_EXT_B); // [R9]
	endfunction : reg_hit

	function automatic logic permit(input logic [MEM_AW-1:0] a,
			input logic wr, input logic [NUM_ATTR-1:0][7:0] at);
		logic [MEM_AW-1:0] off;
		logic [3:0] seg;
		logic [2:0] slot;
		off = a - VIDEO_TOP;
		seg = off[SEG_SHIFT+:4];
		slot = seg[3:1] + FIRST_EXP_REG; // [R10] [R11]
		if (a >= BIOS_BASE) begin
			return wr ? at[BIOS_REG][WP_HI] : at[BIOS_REG][RP_HI]; // [R12]
		end
		if (seg[0]) begin
			return wr ? at[slot][WP_HI] : at[slot][RP_HI]; // [R3]
		end
		return wr ? at[slot][WP_LO] : at[slot][RP_LO]; // [R3]
	endfunction : permit

	function automatic logic to_dram(input mem_req_t q, input logic host,
			input logic [NUM_ATTR-1:0][7:0] at, input logic [1:0] c);
		if (q.addr < DOS_TOP) begin
			return 1'b1; // [R13]
		end
		if (q.addr < HOLE_TOP) begin
			return !c[CTRL_HOLE]; // [R14]
		end
		if (q.addr < VIDEO_TOP) begin
			return host && q.smm && c[CTRL_MGMT]; // [R15]
		end
		// Same permits for both initiators
		return permit(q.addr, q.write, at); // [R1] [R2] [R4] [R5] [R6] [R7] [R8]
	endfunction : to_dram

	// ***********************************
	// Strap synchroniser
	// ***********************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			strap_s1_r <= 1'b0;
			strap_s2_r <= 1'b0;
			strap_s3_r <= 1'b0;
		end else begin
			strap_s1_r <= non_native_strap;
			strap_s2_r <= strap_s1_r;
			strap_s3_r <= strap_s2_r;
		end
	end

	// Level taken only once two stages agree
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			strap_r <= 1'b0;
		end else if (strap_s2_r == strap_s3_r) begin
			strap_r <= strap_s3_r;
		end
	end

	// ***********************************
	// Write channel
	// ***********************************
	assign awready = !aw_full_r && !bvalid;
	assign wready = !w_full_r && !bvalid;
	assign do_write = aw_full_r && w_full_r && !bvalid;
	assign wr_idx = aw_addr_r[ADDR_W-1:2];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_r <= 1'b0;
			aw_addr_r <= '0;
		end else if (awvalid && awready) begin
			aw_full_r <= 1'b1;
			aw_addr_r <= awaddr;
		end else if (do_write) begin
			aw_full_r <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_full_r <= 1'b0;
			w_data_r <= '0;
			w_strb_r <= '0;
		end else if (wvalid && wready) begin
			w_full_r <= 1'b1;
			w_data_r <= wdata;
			w_strb_r <= wstrb;
		end else if (do_write) begin
			w_full_r <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		logic [2:0] slot;
		logic hit;
		slot = '0;
		hit = reg_hit(aw_addr_r, slot);
		if (!aresetn) begin
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
		end else if (do_write) begin
			bvalid <= 1'b1;
			bresp <= (hit || (aw_addr_r[1:0] == 2'h0 &&
				(wr_idx == IDX_CONTROL || wr_idx == IDX_STATUS))) ?
				RESP_OKAY : RESP_DECERR;
		end else if (bready) begin
			bvalid <= 1'b0;
		end
	end

	// Reserved bits never stored, so they read back zero
	always_ff @(posedge aclk) begin
		logic [2:0] slot;
		logic hit;
		slot = '0;
		hit = reg_hit(aw_addr_r, slot);
		if (!aresetn) begin
			attr_r <= {NUM_ATTR{ATTR_RESET}}; // [R18]
		end else if (do_write && hit && w_strb_r[0]) begin
			attr_r[slot] <= w_data_r[7:0] &
				((slot == BIOS_REG) ? BIOS_MASK : ATTR_MASK); // [R3] [R12] [R18]
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_r <= CTRL_RESET;
		end else if (do_write && wr_idx == IDX_CONTROL &&
				aw_addr_r[1:0] == 2'h0 && w_strb_r[0]) begin
			ctrl_r <= w_data_r[1:0];
		end
	end

	// ***********************************
	// Read channel
	// ***********************************
	assign arready = !rvalid;

	always_ff @(posedge aclk) begin
		logic [2:0] slot;
		logic hit;
		logic [9:0] idx;
		slot = '0;
		hit = reg_hit(araddr, slot);
		idx = araddr[ADDR_W-1:2];
		if (!aresetn) begin
			rvalid <= 1'b0;
			rdata <= '0;
			rresp <= RESP_OKAY;
		end else if (arvalid && arready) begin
			rvalid <= 1'b1;
			rresp <= RESP_OKAY;
			rdata <= '0;
			if (hit) begin
				rdata[7:0] <= attr_r[slot];
			end else if (araddr[1:0] == 2'h0 && idx == IDX_CONTROL) begin
				rdata[1:0] <= ctrl_r;
			end else if (araddr[1:0] == 2'h0 && idx == IDX_STATUS) begin
				rdata[4:0] <= {strap_r, hub_route.refused,
					hub_route.to_dram, host_route.to_dram, host_route.valid};
			end else begin
				rresp <= RESP_DECERR;
			end
		end else if (rready) begin
			rvalid <= 1'b0;
		end
	end

	// ***********************************
	// Routing decisions
	// ***********************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			host_route <= '0;
		end else begin
			host_route.valid <= host_req.valid;
			host_route.refused <= 1'b0;
			if (host_req.valid) begin
				host_route.to_dram <= to_dram(host_req, 1'b1, attr_r,
					ctrl_r); // [R1] [R2] [R13] [R14] [R15]
			end
		end
	end

	// Hub never reaches video DRAM; refusal flagged when guarded
	always_ff @(posedge aclk) begin
		logic vid;
		vid = (hub_req.addr >= HOLE_TOP) && (hub_req.addr < VIDEO_TOP);
		if (!aresetn) begin
			hub_route <= '0;
		end else begin
			hub_route.valid <= hub_req.valid;
			if (hub_req.valid) begin
				hub_route.to_dram <= to_dram(hub_req, 1'b0, attr_r,
					ctrl_r); // [R8] [R4] [R5] [R6] [R7]
				hub_route.refused <= vid &&
					(ctrl_r[CTRL_MGMT] || strap_r); // [R16]
			end
		end
	end

	// ***********************************
	// Checks
	// ***********************************
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	sequence s_host_bios(logic wr);
		host_req.valid && host_req.addr >= BIOS_BASE &&
			host_req.write == wr;
	endsequence

	sequence s_route_out(logic exp);
		##1 host_route.valid && host_route.to_dram == exp;
	endsequence

	chk_low_dram: assert property ( // [R13]
		host_req.valid && host_req.addr < DOS_TOP |=>
			host_route.valid && host_route.to_dram)
		else $error("low region not routed to DRAM");

	chk_bios_read: assert property ( // [R1]
		s_host_bios(1'b0) |->
			s_route_out($past(attr_r[BIOS_REG][RP_HI])))
		else $error("bios read routing mismatch");

	chk_bios_write: assert property ( // [R2]
		s_host_bios(1'b1) |->
			s_route_out($past(attr_r[BIOS_REG][WP_HI])))
		else $error("bios write routing mismatch");

	chk_hub_disabled: assert property ( // [R4]
		hub_req.valid && hub_req.addr >= BIOS_BASE &&
			attr_r[BIOS_REG][5:4] == 2'h0 |=> !hub_route.to_dram)
		else $error("hub claimed disabled segment");

	chk_video_host: assert property ( // [R15]
		host_req.valid && host_req.addr >= HOLE_TOP &&
			host_req.addr < VIDEO_TOP && !host_req.smm |=>
			!host_route.to_dram)
		else $error("video access claimed outside smm");

	chk_video_refuse: assert property ( // [R16]
		hub_req.valid && hub_req.addr >= HOLE_TOP &&
			hub_req.addr < VIDEO_TOP && strap_r |=>
			hub_route.refused && !hub_route.to_dram)
		else $error("hub video not refused");

	chk_reserved_zero: assert property ( // [R18]
		(attr_r[BIOS_REG] & ~BIOS_MASK) == 8'h00 &&
			(attr_r[FIRST_EXP_REG] & ~ATTR_MASK) == 8'h00)
		else $error("reserved attribute bit set");

	chk_hole_route: assert property ( // [R14]
		host_req.valid && host_req.addr >= DOS_TOP &&
			host_req.addr < HOLE_TOP |=>
			host_route.to_dram == !$past(ctrl_r[CTRL_HOLE]))
		else $error("hole routing mismatch");

	chk_strap_agree: assert property (
		strap_s2_r != strap_s3_r |=> strap_r == $past(strap_r))
		else $error("strap taken before stages agreed");

	// ***********************************
	// Bus, lowest segment and hub video checks
	// ***********************************
	// Answer one cycle after both halves held
	chk_write_answer: assert property (
		aw_full_r && w_full_r && !bvalid |=> bvalid)
		else $error("write response not raised");

	// Read answer blocks the next address
	chk_read_stall: assert property (
		rvalid |-> !arready)
		else $error("read address open during answer");

	// One write in flight: address and data held off
	chk_write_stall: assert property (
		bvalid |-> !awready && !wready)
		else $error("write channel open during response");

	// Segment zero: lowest expansion window
	function automatic logic in_seg0(input logic [MEM_AW-1:0] a);
		return a[MEM_AW-1:SEG_SHIFT] == VIDEO_TOP[MEM_AW-1:SEG_SHIFT];
	endfunction : in_seg0

	sequence s_hub_seg0_read;
		hub_req.valid && !hub_req.write && in_seg0(hub_req.addr);
	endsequence

	chk_seg0_host_wr: assert property ( // [R2] [R10]
		host_req.valid && host_req.write && in_seg0(host_req.addr) |=>
			host_route.to_dram == $past(attr_r[FIRST_EXP_REG][WP_LO]))
		else $error("lowest segment host write mismatch");

	chk_seg0_hub_rd: assert property ( // [R8] [R10]
		s_hub_seg0_read |=>
			hub_route.to_dram == $past(attr_r[FIRST_EXP_REG][RP_LO]))
		else $error("lowest segment hub read mismatch");

	chk_hub_video: assert property ( // [R16]
		hub_req.valid && hub_req.addr >= HOLE_TOP &&
			hub_req.addr < VIDEO_TOP |=> !hub_route.to_dram)
		else $error("hub video access claimed");

endmodule : legacy_segment_attribute_decoder

// File: verification/access_source.sv
/*
 * Host and hub request source facing the attribute decoder.
 * Assumes bench commands change just after a rising aclk edge.
 */
`timescale 1ns/1ps
module access_source
	import legacy_attr_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Bench command
	input wire logic go,
	input wire logic wr,
	input wire logic smm,
	input wire logic [19:0] addr,
	// Requests
	output legacy_attr_pkg::mem_req_t host_req,
	output legacy_attr_pkg::mem_req_t hub_req
);
	import legacy_attr_pkg::*;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			host_req <= '0;
			hub_req <= '0;
		end else if (go) begin
			host_req <= '{1'b1, wr, smm, addr};
			hub_req <= '{1'b1, wr, 1'b0, addr};
		end else begin
			// Idle fields scramble so stale values never pass
			host_req <= {1'b0, ~host_req[21:0]};
			hub_req <= {1'b0, ~hub_req[21:0]};
		end
	end
endmodule : access_source

// File: verification/legacy_segment_attribute_decoder_tb.sv
/*
 * Self-checking bench of the attribute decoder.
 * Assumes the package and the request source are compiled first.
 */
`timescale 1ns/1ps
`define CHK(n, e, s) \
	begin \
	checks++; \
	if ((s) !== (e)) begin \
	fail_count++; \
	$display("[ERR] %s exp %0h seen %0h", n, e, s); \
	end \
	end
module legacy_segment_attribute_decoder_tb
	import legacy_attr_pkg::*;
;
	logic aclk = 0, aresetn = 0, go = 0, wr = 0, smm = 0, strap = 0;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [11:0] awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, rdata, rd;
	logic [1:0] bresp, rresp, resp;
	logic [19:0] addr = 0, a;
	logic [7:0] attr_m [7];
	logic hole_m = 0, mgmt_m = 0;
	mem_req_t host_req, hub_req;
	route_t host_route, hub_route;
	int fail_count = 0, checks = 0, cyc = 0;
	legacy_segment_attribute_decoder dut (.aclk(aclk), .aresetn(aresetn),
		.awvalid(awvalid), .awready(awready), .awaddr(awaddr),
		.awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata),
		.wstrb(4'hF), .bvalid(bvalid), .bready(bready), .bresp(bresp),
		.arvalid(arvalid), .arready(arready), .araddr(araddr),
		.arprot(3'h0), .rvalid(rvalid), .rready(rready), .rdata(rdata),
		.rresp(rresp), .host_req(host_req), .hub_req(hub_req),
		.host_route(host_route), .hub_route(hub_route),
		.non_native_strap(strap));
	access_source src (.aclk(aclk), .aresetn(aresetn), .go(go), .wr(wr),
		.smm(smm), .addr(addr), .host_req(host_req), .hub_req(hub_req));
	initial begin
		forever #12.5 aclk = ~aclk;
	end
	// ***********************************
	// Bus tasks
	// ***********************************
	task conclude;
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : conclude
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 40000) begin
			fail_count++;
			conclude();
		end
	end
	task axw(input logic [11:0] ad, input logic [31:0] d);
		logic at, wt;
		at = 0;
		wt = 0;
		@(posedge aclk);
		awaddr <= ad;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (!(at && wt)) begin
			@(negedge aclk);
			at = at | (awvalid & awready);
			wt = wt | (wvalid & wready);
			@(posedge aclk);
			if (at) awvalid <= 1'b0;
			if (wt) wvalid <= 1'b0;
		end
		bready <= 1'b1;
		do @(negedge aclk); while (bvalid !== 1'b1);
		resp = bresp;
		@(posedge aclk);
		bready <= 1'b0;
	endtask : axw
	task axr(input logic [11:0] ad);
		@(posedge aclk);
		araddr <= ad;
		arvalid <= 1'b1;
		do @(negedge aclk); while (arready !== 1'b1);
		@(posedge aclk);
		arvalid <= 1'b0;
		rready <= 1'b1;
		do @(negedge aclk); while (rvalid !== 1'b1);
		rd = rdata;
		resp = rresp;
		@(posedge aclk);
		rready <= 1'b0;
	endtask : axr
	// Register index 59h+i sits at byte 4*(59h+i)
	task wreg(input int i, input logic [7:0] d);
		axw(12'h164 + 12'(4 * i), {24'h0, d});
		attr_m[i] = d & (i == 0 ? 8'h30 : 8'h33);
		`CHK("bresp", RESP_OKAY, resp)
	endtask : wreg
	task wctl(input logic [1:0] c);
		axw(12'h200, {30'h0, c});
		hole_m = c[0];
		mgmt_m = c[1];
		`CHK("control bresp", RESP_OKAY, resp)
		axr(12'h200);
		`CHK("control", {30'h0, c}, rd)
	endtask : wctl
	// ***********************************
	// Expected routing
	// ***********************************
	function automatic logic [1:0] exp_r(input logic h, w, s,
		input logic [19:0] ad);
		int seg;
		logic [7:0] v;
		if (ad < 20'h80000) return 2'b10;
		if (ad < 20'hA0000) return {!hole_m, 1'b0};
		if (ad < 20'hC0000) return h ? {1'b0, mgmt_m | strap} : {s & mgmt_m, 1'b0};
		seg = ad < 20'hF0000 ? int'((ad - 20'hC0000) >> 14) : 1;
		v = ad < 20'hF0000 ? attr_m[1 + seg / 2] : attr_m[0];
		return {v[(seg % 2) * 4 + (w ? 1 : 0)], 1'b0};
	endfunction : exp_r
	task acc(input logic w, s, input logic [19:0] ad);
		logic [1:0] eh, eb;
		eh = exp_r(0, w, s, ad);
		eb = exp_r(1, w, s, ad);
		@(posedge aclk);
		go <= 1'b1;
		wr <= w;
		smm <= s;
		addr <= ad;
		@(posedge aclk);
		go <= 1'b0;
		@(posedge aclk);
		#1;
		`CHK("host valid", 1'b1, host_route.valid)
		`CHK("host dram", eh[1], host_route.to_dram)
		`CHK("host refused", 1'b0, host_route.refused)
		`CHK("hub valid", 1'b1, hub_route.valid)
		`CHK("hub dram", eb[1], hub_route.to_dram)
		`CHK("hub refused", eb[0], hub_route.refused)
	endtask : acc
	// ***********************************
	// Tests
	// ***********************************
	initial begin
		void'($urandom(32'h184A5039));
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		for (int i = 0; i < 7; i++) begin
			axr(12'h164 + 12'(4 * i));
			`CHK("reset value", 32'h0, rd)
		end
		axr(12'h100);
		`CHK("unmapped rresp", RESP_DECERR, resp)
		axw(12'h100, 32'hFF);
		`CHK("unmapped bresp", RESP_DECERR, resp)
		for (int i = 0; i < 7; i++) begin
			wreg(i, 8'($urandom));
			axr(12'h164 + 12'(4 * i));
			`CHK("readback", {24'h0, attr_m[i]}, rd)
		end
		$display("test registers ended");
		for (int m = 0; m < 4; m++) begin
			for (int i = 0; i < 7; i++) wreg(i, 8'(m * 8'h11) | 8'hCC);
			for (int g = 0; g < 13; g++) begin
				a = g == 12 ? 20'hF0000 : 20'hC0000 + 20'(g << 14);
				a = a | 20'($urandom % 16384);
				acc(0, 0, a);
				acc(1, 0, a);
			end
		end
		$display("test modes ended");
		wreg(1, 8'h02);
		acc(0, 0, 20'hC0010);
		acc(1, 0, 20'hC0010);
		wreg(1, 8'h01);
		acc(1, 0, 20'hC0010);
		$display("test shadow ended");
		repeat (40) begin
			wctl(2'($urandom));
			wreg($urandom % 7, 8'($urandom));
			repeat (8) begin
				a = 20'($urandom);
				acc(1'($urandom), 1'($urandom), a);
			end
			acc(0, 1, 20'h7FFFF);
			acc(1, 0, 20'h9FFFF);
			acc(0, 1'($urandom), 20'hBFFFF);
		end
		$display("test random ended");
		wctl(2'h0);
		strap <= 1'b1;
		repeat (6) @(posedge aclk);
		acc(0, 0, 20'hA0000);
		// Status: synced strap and hub refusal up, rest low
		axr(12'h204);
		`CHK("status", 32'h18, rd)
		strap <= 1'b0;
		repeat (6) @(posedge aclk);
		acc(1, 0, 20'hA0000);
		$display("test strap ended");
		conclude();
	end
endmodule : legacy_segment_attribute_decoder_tb
